// file: fspc_pkg.sv
// Purpose: Shared constants and types of the flash self-program controller
// Assumes: One core instruction slot per clk cycle
// Notes:   Control bit positions are chosen for this block
`default_nettype none
package fspc_pkg;

    localparam int DATA_W = 14;
    localparam int ADDR_W = 15;
    localparam int ADLO_W = 8;
    localparam int ADHI_W = ADDR_W - ADLO_W;
    localparam int DTLO_W = 8;
    localparam int DTHI_W = DATA_W - DTLO_W;
    localparam int ROW_WORDS = 32;
    localparam int LAT_IDX_W = 5;
    localparam int ROW_W = ADDR_W - LAT_IDX_W;
    localparam int SFR_W = 8;

    localparam logic [DATA_W-1:0] BLANK_WORD = 14'h3fff;
    localparam logic [SFR_W-1:0] KEY_FIRST = 8'h55;
    localparam logic [SFR_W-1:0] KEY_SECOND = 8'haa;
    localparam logic [LAT_IDX_W-1:0] LAST_IDX = 5'h1f;

    // Control register bit positions
    localparam int CTL_RD = 0;
    localparam int CTL_WR = 1;
    localparam int CTL_WRITE_ALLOW_BIT = 2;
    localparam int CTL_ABORT = 3;
    localparam int CTL_ERASE = 4;
    localparam int CTL_LATCH = 5;
    localparam int CTL_CFG = 6;

    // Erase and row program time
    localparam int unsigned CLK_PERIOD_PS = 4000;
    localparam int unsigned OP_TIME_US = 2000;
    localparam int unsigned OP_CYCLES = OP_TIME_US * 1000 * 1000 / CLK_PERIOD_PS;
    localparam int TMR_W = 20;

    typedef enum logic [2:0] {
        SEL_CTRL, SEL_KEY, SEL_DAT_LO, SEL_DAT_HI, SEL_ADR_LO, SEL_ADR_HI
    } fspc_sel_t;

    typedef enum logic [3:0] {
        ST_IDLE, ST_RD_SLOT1, ST_RD_ACCESS, ST_RD_CAPT,
        ST_WR_NOP1, ST_WR_NOP2, ST_ERASE, ST_PROG, ST_WAIT
    } fspc_state_t;

    typedef enum logic [1:0] {OP_NONE, OP_LOAD, OP_ERASE, OP_PROG} fspc_op_t;

    typedef enum logic [1:0] {UL_IDLE, UL_HALF, UL_ARMED} fspc_ul_t;

endpackage
`default_nettype wire

// file: fspc_latch_if.sv
// Purpose: Carrier between controller and write latch bank
// Assumes: Single clock domain
// Notes:   Read side is combinational inside the bank
`timescale 1ns/100ps
`default_nettype none
interface fspc_latch_if;
    import fspc_pkg::*;
    logic load;
    logic [LAT_IDX_W-1:0] idx;
    logic [DATA_W-1:0] wdata;
    logic clear;
    logic [LAT_IDX_W-1:0] rd_idx;
    logic [DATA_W-1:0] rd_data;
    logic rd_loaded;
    modport ctrl (output load, idx, wdata, clear, rd_idx, input rd_data, rd_loaded);
    modport bank (input load, idx, wdata, clear, rd_idx, output rd_data, rd_loaded);
endinterface
`default_nettype wire

// file: fspc_latch_bank.sv
// Purpose: Row of write latches with per-word loaded marks
// Assumes: Clear and load never in the same cycle
// Notes:   Unloaded words stay blank and are skipped on row program
`timescale 1ns/100ps
`default_nettype none
module fspc_latch_bank (
    input wire logic clk,
    input wire logic sys_rst,
    fspc_latch_if.bank bus
);
    import fspc_pkg::*;

    logic [DATA_W-1:0] mem_ff [ROW_WORDS];
    logic used_ff [ROW_WORDS];

    // ----------------------------------------
    // Latch entries
    // ----------------------------------------
    for (genvar i = 0; i < ROW_WORDS; i++) begin : g_lat
        wire logic hit = bus.load && (bus.idx == LAT_IDX_W'(i));
        always_ff @(posedge clk) begin
            if (sys_rst || bus.clear) begin
                mem_ff[i] <= BLANK_WORD;
                used_ff[i] <= 1'b0;
            end else if (hit) begin
                mem_ff[i] <= bus.wdata;
                used_ff[i] <= 1'b1;
            end
        end
    end

    assign bus.rd_data = mem_ff[bus.rd_idx];
    assign bus.rd_loaded = used_ff[bus.rd_idx];

endmodule
`default_nettype wire

// file: fspc_unlock.sv
// Purpose: Tracks the two-key unlock pattern
// Assumes: acc pulses once per register access
// Notes:   Armed state is consumed by the next access
`timescale 1ns/100ps
`default_nettype none
module fspc_unlock (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic brk,
    input wire logic acc,
    input wire logic key_we,
    input wire logic [fspc_pkg::SFR_W-1:0] key_data,
    output logic armed
);
    import fspc_pkg::*;

    fspc_ul_t ul_ff;
    fspc_ul_t nxt_ul;

    wire logic first_ok = key_we && (key_data == KEY_FIRST);
    wire logic second_ok = key_we && (key_data == KEY_SECOND) && (ul_ff == UL_HALF);

    // Any other access or a wrong key drops back to idle
    always_comb begin
        nxt_ul = ul_ff;
        if (brk) begin
            nxt_ul = UL_IDLE;
        end else if (acc) begin
            if (first_ok) begin
                nxt_ul = UL_HALF;
            end else if (second_ok) begin
                nxt_ul = UL_ARMED;
            end else begin
                nxt_ul = UL_IDLE;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ul_ff <= UL_IDLE;
        end else begin
            ul_ff <= nxt_ul;
        end
    end

    assign armed = (ul_ff == UL_ARMED);

endmodule
`default_nettype wire

// file: fspc_ctrl.sv
// Purpose: Flash self-program controller, top level
// Assumes: One instruction slot per clk; array returns read data the cycle after flash_rd
// Notes:   Register access is a plain select/strobe port from the core
`timescale 1ns/100ps
`default_nettype none
module fspc_ctrl #(
    parameter int unsigned OP_CYCLES = fspc_pkg::OP_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic dev_rst,
    input wire logic irq_entry,
    input wire fspc_pkg::fspc_sel_t sfr_sel,
    input wire logic sfr_we,
    input wire logic sfr_re,
    input wire logic [fspc_pkg::SFR_W-1:0] sfr_wdata,
    output logic [fspc_pkg::SFR_W-1:0] sfr_rdata_ff,
    output logic core_squash_ff,
    output logic core_stall_ff,
    output logic flash_rd_ff,
    output logic flash_erase_ff,
    output logic flash_wr_ff,
    output logic flash_cfg_ff,
    output logic [fspc_pkg::ADDR_W-1:0] flash_addr_ff,
    output logic [fspc_pkg::DATA_W-1:0] flash_wdata_ff,
    input wire logic [fspc_pkg::DATA_W-1:0] flash_rdata
);
    import fspc_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [ADLO_W-1:0] adr_lo_ff;
    logic [ADHI_W-1:0] adr_hi_ff;
    logic [DTLO_W-1:0] dat_lo_ff;
    logic [DTHI_W-1:0] dat_hi_ff;
    logic rd_ff;
    logic wr_ff;
    logic write_allow_bit_ff;
    logic abort_ff;
    logic erase_sel_ff;
    logic latch_only_ff;
    logic cfg_sel_ff;
    fspc_state_t st_ff;
    fspc_state_t nxt_st;
    fspc_op_t op_ff;
    logic [TMR_W-1:0] tmr_ff;
    logic [LAT_IDX_W-1:0] idx_ff;
    logic [SFR_W-1:0] ctl_view;
    logic unlocked;

    fspc_latch_if lat_bus ();

    // ----------------------------------------
    // Access decode
    // ----------------------------------------
    wire logic ctl_we = sfr_we && (sfr_sel == SEL_CTRL);
    wire logic key_we = sfr_we && (sfr_sel == SEL_KEY);
    wire logic dlo_we = sfr_we && (sfr_sel == SEL_DAT_LO);
    wire logic dhi_we = sfr_we && (sfr_sel == SEL_DAT_HI);
    wire logic alo_we = sfr_we && (sfr_sel == SEL_ADR_LO);
    wire logic ahi_we = sfr_we && (sfr_sel == SEL_ADR_HI);
    wire logic sfr_acc = sfr_we || sfr_re;

    wire logic idle = (st_ff == ST_IDLE);
    wire logic rd_set = ctl_we && sfr_wdata[CTL_RD] && idle && !wr_ff;
    wire logic wr_set = ctl_we && sfr_wdata[CTL_WR] && !sfr_wdata[CTL_RD] && idle && !rd_ff;
    wire logic wr_go = wr_set && unlocked && write_allow_bit_ff;

    // Operation kind taken from the select bits held from the previous control write, not those in the start write
    wire fspc_op_t op_kind = erase_sel_ff ? OP_ERASE :
                             latch_only_ff ? OP_LOAD : OP_PROG;
    wire fspc_op_t nxt_op = wr_go ? op_kind : OP_NONE;

    wire logic wait_done = (tmr_ff == TMR_W'(OP_CYCLES - 1));
    wire logic rd_capt = (st_ff == ST_RD_CAPT);
    wire logic nop_end = (st_ff == ST_WR_NOP2);
    wire logic short_done = nop_end && ((op_ff == OP_NONE) || (op_ff == OP_LOAD));
    wire logic long_done = (st_ff == ST_WAIT) && wait_done;
    wire logic in_write = (op_ff != OP_NONE) && !idle && !(st_ff inside
                          {ST_RD_SLOT1, ST_RD_ACCESS, ST_RD_CAPT});

    wire logic [ROW_W-1:0] row_sel = {adr_hi_ff, adr_lo_ff[ADLO_W-1:LAT_IDX_W]};
    wire logic [LAT_IDX_W-1:0] word_sel = adr_lo_ff[LAT_IDX_W-1:0];

    // ----------------------------------------
    // Unlock tracker and latch bank
    // ----------------------------------------
    fspc_unlock u_unlock (
        .clk(clk),
        .sys_rst(sys_rst),
        .brk(dev_rst || irq_entry),
        .acc(sfr_acc),
        .key_we(key_we),
        .key_data(sfr_wdata),
        .armed(unlocked)
    );

    fspc_latch_bank u_latch (
        .clk(clk),
        .sys_rst(sys_rst),
        .bus(lat_bus)
    );

    assign lat_bus.load = nop_end && (op_ff == OP_LOAD);
    assign lat_bus.idx = word_sel;
    assign lat_bus.wdata = {dat_hi_ff, dat_lo_ff};
    assign lat_bus.clear = long_done;
    assign lat_bus.rd_idx = idx_ff;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            ST_IDLE: begin
                if (rd_set) begin
                    nxt_st = ST_RD_SLOT1;
                end else if (wr_set) begin
                    nxt_st = ST_WR_NOP1;
                end
            end
            ST_RD_SLOT1: nxt_st = ST_RD_ACCESS;
            ST_RD_ACCESS: nxt_st = ST_RD_CAPT;
            ST_RD_CAPT: nxt_st = ST_IDLE;
            ST_WR_NOP1: nxt_st = ST_WR_NOP2;
            ST_WR_NOP2: begin
                if (op_ff == OP_ERASE) begin
                    nxt_st = ST_ERASE;
                end else if (op_ff == OP_PROG) begin
                    nxt_st = ST_PROG;
                end else begin
                    nxt_st = ST_IDLE;
                end
            end
            ST_ERASE: nxt_st = ST_WAIT;
            ST_PROG: begin
                if (idx_ff == LAST_IDX) begin
                    nxt_st = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (wait_done) begin
                    nxt_st = ST_IDLE;
                end
            end
            default: nxt_st = ST_IDLE;
        endcase
        if (dev_rst) begin
            nxt_st = ST_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_ff <= ST_IDLE;
            op_ff <= OP_NONE;
            tmr_ff <= '0;
            idx_ff <= '0;
        end else begin
            st_ff <= nxt_st;
            if (idle) begin
                op_ff <= nxt_op;
            end
            tmr_ff <= (st_ff == ST_WAIT) ? tmr_ff + 1'b1 : '0;
            idx_ff <= (st_ff == ST_PROG) ? idx_ff + 1'b1 : '0;
        end
    end

    // ----------------------------------------
    // Control bits
    // ----------------------------------------
    wire logic nxt_rd = dev_rst ? 1'b0 : rd_set ? 1'b1 : rd_capt ? 1'b0 : rd_ff;
    wire logic nxt_wr = dev_rst ? 1'b0 : wr_set ? 1'b1 :
                        (short_done || long_done) ? 1'b0 : wr_ff;
    // Hardware set wins over a software clear in the same cycle
    wire logic nxt_abort = (dev_rst && in_write) ? 1'b1 :
                           ctl_we ? sfr_wdata[CTL_ABORT] : abort_ff;
    wire logic nxt_write_allow_bit = dev_rst ? 1'b0 : ctl_we ? sfr_wdata[CTL_WRITE_ALLOW_BIT] : write_allow_bit_ff;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_ff <= 1'b0;
            wr_ff <= 1'b0;
            write_allow_bit_ff <= 1'b0;
            abort_ff <= 1'b0;
            erase_sel_ff <= 1'b0;
            latch_only_ff <= 1'b0;
            cfg_sel_ff <= 1'b0;
        end else begin
            rd_ff <= nxt_rd;
            wr_ff <= nxt_wr;
            write_allow_bit_ff <= nxt_write_allow_bit;
            abort_ff <= nxt_abort;
            if (ctl_we) begin
                erase_sel_ff <= sfr_wdata[CTL_ERASE];
                latch_only_ff <= sfr_wdata[CTL_LATCH];
                cfg_sel_ff <= sfr_wdata[CTL_CFG];
            end
        end
    end

    // ----------------------------------------
    // Address and data pairs
    // ----------------------------------------
    wire logic [ADLO_W-1:0] nxt_alo = alo_we ? sfr_wdata : adr_lo_ff;
    wire logic [ADHI_W-1:0] nxt_ahi = ahi_we ? sfr_wdata[ADHI_W-1:0] : adr_hi_ff;
    wire logic [DTLO_W-1:0] nxt_dlo = rd_capt ? flash_rdata[DTLO_W-1:0] :
                                      dlo_we ? sfr_wdata : dat_lo_ff;
    wire logic [DTHI_W-1:0] nxt_dhi = rd_capt ? flash_rdata[DATA_W-1:DTLO_W] :
                                      dhi_we ? sfr_wdata[DTHI_W-1:0] : dat_hi_ff;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            adr_lo_ff <= '0;
            adr_hi_ff <= '0;
            dat_lo_ff <= '0;
            dat_hi_ff <= '0;
        end else begin
            adr_lo_ff <= nxt_alo;
            adr_hi_ff <= nxt_ahi;
            dat_lo_ff <= nxt_dlo;
            dat_hi_ff <= nxt_dhi;
        end
    end

    // ----------------------------------------
    // Register read mux
    // ----------------------------------------
    always_comb begin
        ctl_view = '0;
        ctl_view[CTL_RD] = rd_ff;
        ctl_view[CTL_WR] = wr_ff;
        ctl_view[CTL_WRITE_ALLOW_BIT] = write_allow_bit_ff;
        ctl_view[CTL_ABORT] = abort_ff;
        ctl_view[CTL_ERASE] = erase_sel_ff;
        ctl_view[CTL_LATCH] = latch_only_ff;
        ctl_view[CTL_CFG] = cfg_sel_ff;
    end

    wire logic [SFR_W-1:0] rd_mux =
        (sfr_sel == SEL_CTRL) ? ctl_view :
        (sfr_sel == SEL_DAT_LO) ? dat_lo_ff :
        (sfr_sel == SEL_DAT_HI) ? SFR_W'(dat_hi_ff) :
        (sfr_sel == SEL_ADR_LO) ? adr_lo_ff :
        (sfr_sel == SEL_ADR_HI) ? SFR_W'(adr_hi_ff) : '0;

    // ----------------------------------------
    // Core and array outputs
    // ----------------------------------------
    wire logic nxt_squash = (nxt_st inside {ST_RD_ACCESS, ST_WR_NOP1, ST_WR_NOP2});
    // Only instruction issue halts; clocks keep running
    wire logic nxt_stall = (nxt_st inside {ST_ERASE, ST_PROG, ST_WAIT});
    wire logic prog_word = (st_ff == ST_PROG) && lat_bus.rd_loaded;
    wire logic [ADDR_W-1:0] nxt_faddr = (st_ff == ST_PROG) ? {row_sel, idx_ff} :
                                        {adr_hi_ff, adr_lo_ff};

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sfr_rdata_ff <= '0;
            core_squash_ff <= 1'b0;
            core_stall_ff <= 1'b0;
            flash_rd_ff <= 1'b0;
            flash_erase_ff <= 1'b0;
            flash_wr_ff <= 1'b0;
            flash_cfg_ff <= 1'b0;
            flash_addr_ff <= '0;
            flash_wdata_ff <= BLANK_WORD;
        end else begin
            sfr_rdata_ff <= sfr_re ? rd_mux : '0;
            core_squash_ff <= nxt_squash;
            core_stall_ff <= nxt_stall;
            flash_rd_ff <= (nxt_st == ST_RD_ACCESS);
            flash_erase_ff <= (nxt_st == ST_ERASE);
            flash_wr_ff <= prog_word && !dev_rst;
            flash_cfg_ff <= cfg_sel_ff;
            flash_addr_ff <= nxt_faddr;
            flash_wdata_ff <= lat_bus.rd_data;
        end
    end

endmodule
`default_nettype wire

// file: fspc_ctrl_asserts.sv
// Purpose: Concurrent checks on the flash self-program controller ports
// Assumes: No operation is started while another one runs
// Notes:   Write-allow is shadowed from control writes
`timescale 1ns/100ps
`default_nettype none
module fspc_ctrl_asserts #(
    parameter int unsigned OP_CYCLES = 20
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic dev_rst,
    input wire logic irq_entry,
    input wire fspc_pkg::fspc_sel_t sfr_sel,
    input wire logic sfr_we,
    input wire logic sfr_re,
    input wire logic [fspc_pkg::SFR_W-1:0] sfr_wdata,
    input wire logic [fspc_pkg::SFR_W-1:0] sfr_rdata_ff,
    input wire logic core_squash_ff,
    input wire logic core_stall_ff,
    input wire logic flash_rd_ff,
    input wire logic flash_erase_ff,
    input wire logic flash_wr_ff
);
    import fspc_pkg::*;
    // ----------------------------------------
    // Helper state
    // ----------------------------------------
    logic ctrl_we;
    logic start_any;
    logic write_allow_bit_sh_ff;
    logic [TMR_W-1:0] stall_run_ff;
    assign ctrl_we = sfr_we && sfr_sel == SEL_CTRL;
    assign start_any = ctrl_we && (sfr_wdata[CTL_RD] || sfr_wdata[CTL_WR]);
    always_ff @(posedge clk) begin
        if (sys_rst || dev_rst) begin
            write_allow_bit_sh_ff <= 1'b0;
        end else if (ctrl_we) begin
            write_allow_bit_sh_ff <= sfr_wdata[CTL_WRITE_ALLOW_BIT];
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst || !core_stall_ff) begin
            stall_run_ff <= '0;
        end else begin
            stall_run_ff <= stall_run_ff + 1'b1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_key(logic [SFR_W-1:0] k);
        sfr_we && sfr_sel == SEL_KEY && sfr_wdata == k;
    endsequence
    sequence s_start(int b);
        ctrl_we && sfr_wdata[b] && sfr_wdata[CTL_RD] != sfr_wdata[CTL_WR] && !core_stall_ff
            && !core_squash_ff && !$past(core_squash_ff) && !$past(start_any);
    endsequence
    sequence s_erase;
        ctrl_we && sfr_wdata[CTL_WR] && sfr_wdata[CTL_ERASE] && !sfr_wdata[CTL_RD] && write_allow_bit_sh_ff
            && !core_stall_ff && !core_squash_ff;
    endsequence
    sequence s_unlock;
        s_key(KEY_FIRST) ##1 s_key(KEY_SECOND) ##1 s_erase;
    endsequence
    property p_rd_seq;
        s_start(CTL_RD) |=> !core_squash_ff ##1 (core_squash_ff && flash_rd_ff);
    endproperty
    property p_wr_squash;
        disable iff (sys_rst || dev_rst) s_start(CTL_WR) |=> core_squash_ff [*2] ##1 !core_squash_ff;
    endproperty
    property p_erase_go;
        disable iff (sys_rst || dev_rst) s_unlock |-> ##3 (flash_erase_ff && core_stall_ff);
    endproperty
    property p_irq_break;
        s_key(KEY_FIRST) ##1 s_key(KEY_SECOND) ##1 (irq_entry && !sfr_we && !sfr_re) ##1 s_erase
            |-> ##3 (!core_stall_ff && !flash_erase_ff);
    endproperty
    property p_load_free;
        ctrl_we && sfr_wdata[CTL_WR] && sfr_wdata[CTL_LATCH] && !sfr_wdata[CTL_ERASE] && !core_stall_ff
            |=> !core_stall_ff [*4];
    endproperty
    property p_key_zero;
        sfr_re && sfr_sel == SEL_KEY |=> sfr_rdata_ff == 8'h00;
    endproperty
    property p_stall_len;
        $fell(core_stall_ff) && !$past(dev_rst)
            |-> stall_run_ff >= OP_CYCLES + 1 && stall_run_ff <= OP_CYCLES + 32;
    endproperty
    property p_wr_stall;
        flash_wr_ff |-> core_stall_ff && !flash_erase_ff;
    endproperty
    a_rd_seq: assert property (p_rd_seq) else $error("read slot timing wrong");
    a_wr_squash: assert property (p_wr_squash) else $error("forced slots wrong");
    a_erase_go: assert property (p_erase_go) else $error("erase did not start");
    a_irq_break: assert property (p_irq_break) else $error("broken unlock started an op");
    a_load_free: assert property (p_load_free) else $error("latch load stalled");
    a_key_zero: assert property (p_key_zero) else $error("key register read not zero");
    a_stall_len: assert property (p_stall_len) else $error("stall length wrong");
    a_wr_stall: assert property (p_wr_stall) else $error("word write outside stall");
endmodule
bind fspc_ctrl fspc_ctrl_asserts #(.OP_CYCLES(OP_CYCLES)) u_chk (
    .clk(clk), .sys_rst(sys_rst), .dev_rst(dev_rst), .irq_entry(irq_entry), .sfr_sel(sfr_sel),
    .sfr_we(sfr_we), .sfr_re(sfr_re), .sfr_wdata(sfr_wdata), .sfr_rdata_ff(sfr_rdata_ff),
    .core_squash_ff(core_squash_ff), .core_stall_ff(core_stall_ff), .flash_rd_ff(flash_rd_ff),
    .flash_erase_ff(flash_erase_ff), .flash_wr_ff(flash_wr_ff)
);
`default_nettype wire

// file: fspc_flash_model.sv
// Purpose: Behavioural flash array behind the controller
// Assumes: Read data is wanted the cycle after the read strobe
// Notes:   Outside a read the data lines toggle every cycle
`timescale 1ns/100ps
`default_nettype none
module fspc_flash_model (
    input wire logic clk,
    input wire logic rd,
    input wire logic erase,
    input wire logic wr,
    input wire logic [fspc_pkg::ADDR_W-1:0] addr,
    input wire logic [fspc_pkg::DATA_W-1:0] wdata,
    output logic [fspc_pkg::DATA_W-1:0] rdata
);
    import fspc_pkg::*;
    logic [DATA_W-1:0] mem [0:(1 << ADDR_W)-1];
    initial begin
        for (int i = 0; i < (1 << ADDR_W); i++) begin
            mem[i] = BLANK_WORD;
        end
        rdata = '0;
    end
    always @(posedge clk) begin
        rdata <= rd ? mem[addr] : ~rdata;
        if (erase) begin
            for (int i = 0; i < ROW_WORDS; i++) begin
                mem[{addr[ADDR_W-1:LAT_IDX_W], LAT_IDX_W'(i)}] <= BLANK_WORD;
            end
        end
        // Programming only clears bits
        if (wr) begin
            mem[addr] <= mem[addr] & wdata;
        end
    end
endmodule
`default_nettype wire

// file: fspc_tb.sv
// Purpose: Self-checking bench for the flash self-program controller
// Assumes: Short operation time through OP_CYCLES
// Notes:   One task per scenario
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import fspc_pkg::*;
    localparam int unsigned OP = 40;
    localparam logic [SFR_W-1:0] B_RD = 8'h01 << CTL_RD;
    localparam logic [SFR_W-1:0] B_WR = 8'h01 << CTL_WR;
    localparam logic [SFR_W-1:0] B_WRITE_ALLOW_BIT = 8'h01 << CTL_WRITE_ALLOW_BIT;
    localparam logic [SFR_W-1:0] B_ERASE = 8'h01 << CTL_ERASE;
    localparam logic [SFR_W-1:0] B_LATCH = 8'h01 << CTL_LATCH;
    logic clk = 1'b0, sys_rst = 1'b1, dev_rst = 1'b0, irq_entry = 1'b0, sfr_we = 1'b0, sfr_re = 1'b0;
    fspc_sel_t sfr_sel = SEL_CTRL;
    logic [SFR_W-1:0] sfr_wdata = 8'h00, sfr_rdata_ff, rv;
    logic core_squash_ff, core_stall_ff, flash_rd_ff, flash_erase_ff, flash_wr_ff, flash_cfg_ff;
    logic [ADDR_W-1:0] flash_addr_ff;
    logic [DATA_W-1:0] flash_wdata_ff, flash_rdata, wv;
    int err_total = 0, checks_done = 0, wr_seen = 0, n;
    fspc_ctrl #(.OP_CYCLES(OP)) dut (.clk(clk), .sys_rst(sys_rst), .dev_rst(dev_rst), .irq_entry(irq_entry),
        .sfr_sel(sfr_sel), .sfr_we(sfr_we), .sfr_re(sfr_re), .sfr_wdata(sfr_wdata), .sfr_rdata_ff(sfr_rdata_ff),
        .core_squash_ff(core_squash_ff), .core_stall_ff(core_stall_ff), .flash_rd_ff(flash_rd_ff),
        .flash_erase_ff(flash_erase_ff), .flash_wr_ff(flash_wr_ff), .flash_cfg_ff(flash_cfg_ff),
        .flash_addr_ff(flash_addr_ff), .flash_wdata_ff(flash_wdata_ff), .flash_rdata(flash_rdata));
    fspc_flash_model u_flash (.clk(clk), .rd(flash_rd_ff), .erase(flash_erase_ff), .wr(flash_wr_ff),
        .addr(flash_addr_ff), .wdata(flash_wdata_ff), .rdata(flash_rdata));
    always #2 clk = ~clk;
    always @(posedge clk) begin
        if (flash_wr_ff === 1'b1) wr_seen <= wr_seen + 1;
    end
    // ----------------------------------------
    // Bus and check helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask
    task automatic wr(input fspc_sel_t s, input logic [SFR_W-1:0] d);
        sfr_sel <= s; sfr_wdata <= d; sfr_we <= 1'b1; sfr_re <= 1'b0;
        @(posedge clk);
    endtask
    task automatic idle();
        sfr_we <= 1'b0; sfr_re <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input fspc_sel_t s);
        sfr_sel <= s; sfr_we <= 1'b0; sfr_re <= 1'b1;
        @(posedge clk);
        sfr_re <= 1'b0;
        #1 rv = sfr_rdata_ff;
        @(posedge clk);
    endtask
    task automatic unlock(input logic [SFR_W-1:0] d);
        wr(SEL_CTRL, d);
        wr(SEL_KEY, KEY_FIRST);
        wr(SEL_KEY, KEY_SECOND);
        wr(SEL_CTRL, d | B_WR);
        idle();
    endtask
    task automatic wait_idle();
        int k;
        k = 0;
        repeat (4) @(posedge clk);
        while (core_stall_ff !== 1'b0 && k < OP + 100) begin
            @(posedge clk);
            k++;
        end
        chk("stall end", 16'h0000, 16'(core_stall_ff));
    endtask
    task automatic rdword(input logic [ADDR_W-1:0] a);
        wr(SEL_ADR_LO, a[7:0]);
        wr(SEL_ADR_HI, {1'b0, a[14:8]});
        wr(SEL_CTRL, B_RD);
        idle();
        idle();
        idle();
        rd(SEL_DAT_LO);
        wv[7:0] = rv;
        rd(SEL_DAT_HI);
        wv[13:8] = rv[5:0];
    endtask
    task automatic load(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        wr(SEL_ADR_LO, a[7:0]);
        wr(SEL_ADR_HI, {1'b0, a[14:8]});
        wr(SEL_DAT_LO, d[7:0]);
        wr(SEL_DAT_HI, {2'b00, d[13:8]});
        unlock(B_WRITE_ALLOW_BIT | B_LATCH);
        repeat (4) @(posedge clk);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        #1 chk("wdata", 16'h3fff, 16'(flash_wdata_ff));
        chk("stall", 16'h0000, 16'(core_stall_ff));
        chk("cfg", 16'h0000, 16'(flash_cfg_ff));
        @(posedge clk);
        rd(SEL_CTRL);
        chk("ctrl", 16'h0000, 16'(rv));
        wr(SEL_CTRL, 8'h01 << CTL_CFG);
        idle();
        idle();
        chk("cfg set", 16'h0001, 16'(flash_cfg_ff));
        wr(SEL_KEY, KEY_SECOND);
        idle();
        rd(SEL_KEY);
        chk("key", 16'h0000, 16'(rv));
        rd(fspc_sel_t'(3'h6));
        chk("unmapped", 16'h0000, 16'(rv));
    endtask
    task automatic t_program();
        load(15'h5a43, 14'h1234);
        load(15'h5a47, 14'h2a5c);
        n = wr_seen;
        unlock(B_WRITE_ALLOW_BIT);
        wait_idle();
        chk("words", 16'h0002, 16'(wr_seen - n));
        rdword(15'h5a43);
        chk("w3", 16'h1234, 16'(wv));
        rd(SEL_DAT_LO);
        chk("hold", 16'h0034, 16'(rv));
        rdword(15'h5a47);
        chk("w7", 16'h2a5c, 16'(wv));
        load(15'h5a49, 14'h0abc);
        n = wr_seen;
        unlock(B_WRITE_ALLOW_BIT);
        wait_idle();
        chk("words", 16'h0001, 16'(wr_seen - n));
        rdword(15'h5a43);
        chk("w3", 16'h1234, 16'(wv));
        rdword(15'h5a49);
        chk("w9", 16'h0abc, 16'(wv));
        rd(SEL_CTRL);
        chk("rd bit", 16'h0000, 16'(rv[CTL_RD]));
    endtask
    task automatic t_erase();
        unlock(B_ERASE);
        wait_idle();
        rdword(15'h5a43);
        chk("no write_allow_bit", 16'h1234, 16'(wv));
        wr(SEL_ADR_LO, 8'h51);
        wr(SEL_ADR_HI, 8'h5a);
        unlock(B_WRITE_ALLOW_BIT | B_ERASE);
        wait_idle();
        rdword(15'h5a43);
        chk("erased", 16'h3fff, 16'(wv));
        rdword(15'h5a49);
        chk("erased", 16'h3fff, 16'(wv));
    endtask
    task automatic t_abort();
        unlock(B_WRITE_ALLOW_BIT | B_ERASE);
        repeat (10) @(posedge clk);
        dev_rst <= 1'b1;
        @(posedge clk);
        dev_rst <= 1'b0;
        wait_idle();
        rd(SEL_CTRL);
        chk("abort", 16'h0001, 16'(rv[CTL_ABORT]));
        chk("wr bit", 16'h0000, 16'(rv[CTL_WR]));
        wr(SEL_CTRL, 8'h00);
        rd(SEL_CTRL);
        chk("abort clr", 16'h0000, 16'(rv[CTL_ABORT]));
    endtask
    task automatic no_go(input fspc_sel_t s, input logic [SFR_W-1:0] d, input logic brk);
        wr(SEL_CTRL, B_WRITE_ALLOW_BIT | B_ERASE);
        wr(SEL_KEY, KEY_FIRST);
        wr(s, d);
        if (brk) begin
            irq_entry <= 1'b1;
            sfr_we <= 1'b0;
            @(posedge clk);
            irq_entry <= 1'b0;
        end
        wr(SEL_CTRL, B_WRITE_ALLOW_BIT | B_ERASE | B_WR);
        idle();
        repeat (4) @(posedge clk);
        chk("locked", 16'h0000, 16'(core_stall_ff));
    endtask
    task automatic finish_test();
        $display("Checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        finish_test();
    end
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_program();
        t_erase();
        no_go(SEL_KEY, KEY_SECOND, 1'b1);
        no_go(SEL_KEY, 8'h5a, 1'b0);
        no_go(SEL_DAT_LO, KEY_SECOND, 1'b0);
        t_abort();
        finish_test();
    end
endmodule
`default_nettype wire
